// *** design/rxc_rx_control.sv ***
`timescale 1ns/10ps
`default_nettype none

module rxc_rx_control (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   // Wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // Frame descriptors from the receive parser
   input wire logic i_rx_valid,
   input wire rxc_pkg::rxc_desc_s i_rx_desc,
   output logic o_rx_ready,
   // Duplex strap from the link pin
   input wire logic i_full_duplex,
   // State toward the transmit side
   output logic o_tx_hold,
   output logic o_rx_running
);
   import rxc_pkg::*;

   // ----------------------------------------
   // Types and helpers
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_STOP = 3'b100
   } rxc_state_e;

   // Word-aligned register match
   function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] off);
      return adr[7:2] == off[7:2];
   endfunction

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [15:0] rx_ctl;
   logic [15:0] next_rx_ctl;
   logic [2:0] duplex_sync;
   logic duplex;
   rxc_state_e state;
   rxc_state_e next_state;
   logic next_ready;
   logic [15:0] pause_quanta;
   logic [15:0] next_pause_quanta;
   logic [RXC_SLOT_W-1:0] pause_slot;
   logic [RXC_SLOT_W-1:0] next_pause_slot;
   logic [7:0] frame_ptr;
   logic [7:0] next_frame_ptr;
   logic [RXC_CNT_W-1:0] fifo_count;
   logic [RXC_CNT_W:0] level_after;
   logic fifo_in_ready;
   logic q_valid;
   logic [RXC_Q_WIDTH-1:0] q_data;
   logic [RXC_Q_WIDTH-1:0] q_entry;
   logic [31:0] status_word;
   logic [31:0] rd_word;
   logic wb_req;
   logic hit_ctl;
   logic hit_st;
   logic hit_q;
   logic wr_ctl;
   logic pop;
   logic flush_en;
   logic udp_en;
   logic tcp_en;
   logic ip_en;
   logic uc_en;
   logic pause_en;
   logic crc_accept;
   logic mc_en;
   logic run_en;
   logic take;
   logic is_uni;
   logic is_multi;
   logic drop_chk;
   logic drop_addr;
   logic drop_crc;
   logic keep;
   logic push;
   logic pause_live;
   logic pause_take;

   // ----------------------------------------
   // Control field decode
   // ----------------------------------------
   assign flush_en = rx_ctl[RXC_FLUSH_BIT];
   assign udp_en = rx_ctl[RXC_UDP_CHK_BIT];
   assign tcp_en = rx_ctl[RXC_TCP_CHK_BIT];
   assign ip_en = rx_ctl[RXC_IP_CHK_BIT];
   assign uc_en = rx_ctl[RXC_UC_FILT_BIT];
   assign pause_en = rx_ctl[RXC_PAUSE_BIT];
   assign crc_accept = rx_ctl[RXC_CRC_ACC_BIT];
   assign mc_en = rx_ctl[RXC_MC_FILT_BIT];
   assign run_en = rx_ctl[RXC_RUN_BIT];

   // ----------------------------------------
   // Wishbone decode
   // ----------------------------------------
   // Ack is registered, so a request is seen once before ack rises
   assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
   assign hit_ctl = addr_hit(i_wb_adr, RXC_RXCTL_OFF);
   assign hit_st = addr_hit(i_wb_adr, RXC_STATUS_OFF);
   assign hit_q = addr_hit(i_wb_adr, RXC_RXQ_OFF);
   // A write lands on the edge where the master samples ack high
   assign wr_ctl = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & hit_ctl;
   // Reading the queue word pops it; an empty queue reads zero
   assign pop = wb_req & ~i_wb_we & hit_q & q_valid;

   // Byte lanes 0 and 1 carry the control word
   assign next_rx_ctl = {i_wb_sel[1] ? i_wb_dat[15:8] : rx_ctl[15:8],
                         i_wb_sel[0] ? i_wb_dat[7:0] : rx_ctl[7:0]};

   // Read data; unmapped words read zero and ignore writes
   assign q_entry = q_valid ? q_data : '0;
   assign status_word = (32'(frame_ptr) << RXC_ST_PTR_LSB)
                      | (32'(o_tx_hold) << RXC_ST_HOLD_BIT)
                      | (32'(o_rx_running) << RXC_ST_RUN_BIT)
                      | (32'(fifo_count) << RXC_ST_CNT_LSB);
   assign rd_word = hit_ctl ? {16'h0000, rx_ctl} :
                    hit_st ? status_word :
                    hit_q ? ((32'(q_valid) << RXC_Q_VALID_BIT) | 32'(q_entry)) :
                    32'h0000_0000;

   // Bus answer and control register
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0000_0000;
         rx_ctl <= RXC_RXCTL_RST;
      end else begin
         o_wb_ack <= wb_req;
         if (wb_req) begin
            o_wb_dat <= rd_word;
         end
         if (wr_ctl) begin
            rx_ctl <= next_rx_ctl;
         end
      end
   end

   // ----------------------------------------
   // Duplex pin synchroniser
   // ----------------------------------------
   // Level changes only once the last two stages agree
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         duplex_sync <= 3'h0;
         duplex <= 1'b0;
      end else begin
         duplex_sync <= {duplex_sync[1:0], i_full_duplex};
         if (duplex_sync[1] == duplex_sync[2]) begin
            duplex <= duplex_sync[2];
         end
      end
   end

   // ----------------------------------------
   // Frame verdict
   // ----------------------------------------
   assign take = i_rx_valid & o_rx_ready;
   assign is_uni = i_rx_desc.dst_kind == RXC_DST_UNI;
   assign is_multi = i_rx_desc.dst_kind == RXC_DST_MULTI;
   assign drop_chk = (udp_en & i_rx_desc.is_udp & i_rx_desc.udp_bad)
                   | (tcp_en & i_rx_desc.is_tcp & i_rx_desc.tcp_bad)
                   | (ip_en & i_rx_desc.is_ip & i_rx_desc.ip_bad);
   assign drop_addr = (is_uni & ~(uc_en & i_rx_desc.addr_match))
                    | (is_multi & ~(mc_en & i_rx_desc.addr_match));
   assign drop_crc = i_rx_desc.crc_err & ~crc_accept;
   // Pause frames are consumed here and never queued
   assign keep = ~i_rx_desc.is_pause & ~drop_chk & ~drop_addr & ~drop_crc;
   assign push = take & keep & ~flush_en & fifo_in_ready;

   // ----------------------------------------
   // Receive queue
   // ----------------------------------------
   rxc_fifo #(
      .WIDTH(RXC_Q_WIDTH),
      .DEPTH(RXC_FIFO_DEPTH)
   ) u_queue (
      .i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst),
      .i_clear(flush_en),
      .i_in_valid(push),
      .o_in_ready(fifo_in_ready),
      .i_in_data({i_rx_desc.crc_err, i_rx_desc.is_ip, i_rx_desc.is_tcp,
                  i_rx_desc.is_udp, 1'b0, i_rx_desc.frame_len}),
      .o_out_valid(q_valid),
      .i_out_ready(pop),
      .o_out_data(q_data),
      .o_count(fifo_count)
   );

   // Frame pointer counts queued frames since the last flush
   assign next_frame_ptr = flush_en ? 8'h00 : frame_ptr + 8'(push);

   // ----------------------------------------
   // Run state and back-pressure
   // ----------------------------------------
   // A beat already offered when run drops is still finished
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (run_en) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!run_en) begin
               next_state = (i_rx_valid && !o_rx_ready) ? ST_STOP : ST_IDLE;
            end
         end
         ST_STOP: begin
            if (take) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Ready is a flop, so it must leave room for the beat taken now
   assign level_after = {1'b0, fifo_count} + (RXC_CNT_W + 1)'(push);
   assign next_ready = (next_state != ST_IDLE) & ~flush_en
                     & (level_after < (RXC_CNT_W + 1)'(RXC_FIFO_DEPTH));

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         state <= ST_IDLE;
         o_rx_ready <= 1'b0;
         o_rx_running <= 1'b0;
         frame_ptr <= 8'h00;
      end else begin
         state <= next_state;
         o_rx_ready <= next_ready;
         o_rx_running <= next_state != ST_IDLE;
         frame_ptr <= next_frame_ptr;
      end
   end

   // ----------------------------------------
   // Pause timer
   // ----------------------------------------
   // Half duplex or honour off kills the timer outright
   assign pause_live = pause_en & duplex;
   assign pause_take = take & i_rx_desc.is_pause & pause_live;
   assign next_pause_quanta =
      !pause_live ? 16'h0000 :
      pause_take ? i_rx_desc.pause_quanta :
      (pause_quanta != 16'h0000 && pause_slot == '0) ? pause_quanta - 16'h0001 :
      pause_quanta;
   assign next_pause_slot =
      !pause_live ? '0 :
      pause_take ? RXC_SLOT_W'(RXC_SLOT_CYCLES - 1) :
      (pause_quanta == 16'h0000) ? pause_slot :
      (pause_slot == '0) ? RXC_SLOT_W'(RXC_SLOT_CYCLES - 1) :
      pause_slot - 1'b1;

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         pause_quanta <= 16'h0000;
         pause_slot <= '0;
         o_tx_hold <= 1'b0;
      end else begin
         pause_quanta <= next_pause_quanta;
         pause_slot <= next_pause_slot;
         o_tx_hold <= next_pause_quanta != 16'h0000;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_sys_rst);

   flush_empty_a: assert property (flush_en |=> fifo_count == '0 && frame_ptr == 8'h00)
      else $error("queue not empty after flush");
   udp_drop_a: assert property (take && udp_en && i_rx_desc.is_udp && i_rx_desc.udp_bad |-> !push)
      else $error("bad UDP frame queued");
   tcp_drop_a: assert property (take && tcp_en && i_rx_desc.is_tcp && i_rx_desc.tcp_bad |-> !push)
      else $error("bad TCP frame queued");
   ip_drop_a: assert property (take && ip_en && i_rx_desc.is_ip && i_rx_desc.ip_bad |-> !push)
      else $error("bad IP header frame queued");
   ucast_filter_a: assert property (take && is_uni && !uc_en |-> !push)
      else $error("unicast queued with filter off");
   pause_hold_a: assert property (pause_take && i_rx_desc.pause_quanta != 16'h0000
                                  |=> o_tx_hold [*8])
      else $error("pause not held");
   pause_off_a: assert property (!pause_en |=> !o_tx_hold)
      else $error("hold while pause honour off");
   crc_keep_a: assert property (take && i_rx_desc.crc_err && crc_accept
                                && !i_rx_desc.is_pause && !drop_chk && !drop_addr |-> push)
      else $error("CRC error frame not queued");
   crc_drop_a: assert property (take && i_rx_desc.crc_err && !crc_accept |-> !push)
      else $error("CRC error frame queued");
   mcast_filter_a: assert property (take && is_multi && !mc_en |-> !push)
      else $error("multicast queued with filter off");
   run_stop_a: assert property (state == ST_RUN && !run_en && !i_rx_valid
                                |=> state == ST_IDLE ##1 !o_rx_ready)
      else $error("reception did not stop");
   half_duplex_a: assert property (!duplex |=> !o_tx_hold)
      else $error("hold in half duplex");
   run_start_a: assert property (state == ST_IDLE && run_en |=> o_rx_running)
      else $error("reception did not start");
   flush_ready_a: assert property (flush_en |=> !o_rx_ready)
      else $error("ready while flushing");
   ucast_pass_a: assert property (take && is_uni && uc_en && i_rx_desc.addr_match
                                  && !i_rx_desc.is_pause && !drop_chk && !drop_crc
                                  && !flush_en |-> push)
      else $error("matching unicast not queued");
   mcast_pass_a: assert property (take && is_multi && mc_en && i_rx_desc.addr_match
                                  && !i_rx_desc.is_pause && !drop_chk && !drop_crc
                                  && !flush_en |-> push)
      else $error("matching multicast not queued");

endmodule // rxc_rx_control

`default_nettype wire

// *** design/rxc_pkg.sv ***
`default_nettype none

package rxc_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] RXC_RXCTL_OFF = 8'h74;
   localparam logic [7:0] RXC_STATUS_OFF = 8'h80;
   localparam logic [7:0] RXC_RXQ_OFF = 8'h84;

   // Receive control field positions
   localparam int RXC_FLUSH_BIT = 15;
   localparam int RXC_UDP_CHK_BIT = 14;
   localparam int RXC_TCP_CHK_BIT = 13;
   localparam int RXC_IP_CHK_BIT = 12;
   localparam int RXC_UC_FILT_BIT = 11;
   localparam int RXC_PAUSE_BIT = 10;
   localparam int RXC_CRC_ACC_BIT = 9;
   localparam int RXC_MC_FILT_BIT = 8;
   localparam int RXC_RUN_BIT = 0;
   localparam logic [15:0] RXC_RXCTL_RST = 16'h0800;

   // Status field positions
   localparam int RXC_ST_CNT_LSB = 0;
   localparam int RXC_ST_RUN_BIT = 6;
   localparam int RXC_ST_HOLD_BIT = 7;
   localparam int RXC_ST_PTR_LSB = 8;
   // Queue read word: entry valid flag
   localparam int RXC_Q_VALID_BIT = 16;

   // ----------------------------------------
   // Queue geometry
   // ----------------------------------------
   localparam int RXC_Q_WIDTH = 16;
   localparam int RXC_FIFO_DEPTH = 32;
   localparam int RXC_CNT_W = $clog2(RXC_FIFO_DEPTH) + 1;

   // ----------------------------------------
   // Pause timing
   // ----------------------------------------
   localparam int RXC_CLK_PERIOD_NS = 10;
   localparam int RXC_BIT_TIME_NS = 10;
   localparam int RXC_QUANTUM_BITS = 512;
   // Least hold per quantum, so rounded up
   localparam int RXC_SLOT_CYCLES =
      (RXC_QUANTUM_BITS * RXC_BIT_TIME_NS + RXC_CLK_PERIOD_NS - 1) / RXC_CLK_PERIOD_NS;
   localparam int RXC_SLOT_W = $clog2(RXC_SLOT_CYCLES);

   // ----------------------------------------
   // Frame descriptor from the receive parser
   // ----------------------------------------
   typedef enum logic [1:0] {
      RXC_DST_UNI = 2'b00,
      RXC_DST_MULTI = 2'b01,
      RXC_DST_BCAST = 2'b10
   } rxc_dst_e;

   typedef struct packed {
      logic [10:0] frame_len;
      logic crc_err;
      logic is_ip;
      logic ip_bad;
      logic is_tcp;
      logic tcp_bad;
      logic is_udp;
      logic udp_bad;
      rxc_dst_e dst_kind;
      logic addr_match;
      logic is_pause;
      logic [15:0] pause_quanta;
   } rxc_desc_s;

endpackage

`default_nettype wire

// *** design/rxc_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none

module rxc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32,
   localparam int AW = $clog2(DEPTH)
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_clear,
   // Fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // Drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   // Fill level
   output logic [AW:0] o_count
);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic wr_en;
   logic rd_en;

   // Handshakes; full and empty come straight from the level
   assign o_in_ready = count < (AW + 1)'(DEPTH);
   assign o_out_valid = count != '0;
   assign wr_en = i_in_valid & o_in_ready;
   assign rd_en = o_out_valid & i_out_ready;
   assign o_out_data = mem[rd_ptr];
   assign o_count = count;

   // One flop word per entry, written by index
   for (genvar g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge i_core_clk) begin
         if (wr_en && wr_ptr == AW'(g)) begin
            mem[g] <= i_in_data;
         end
      end
   end

   // Pointers wrap on their own since depth is a power of two
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst || i_clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= wr_ptr + AW'(wr_en);
         rd_ptr <= rd_ptr + AW'(rd_en);
         count <= count + (AW + 1)'(wr_en) - (AW + 1)'(rd_en);
      end
   end

endmodule // rxc_fifo

`default_nettype wire

// *** bench/rxc_station.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Remote station offering frame descriptors
// ----------------------------------------
module rxc_station (
   // Clock
   input wire logic i_core_clk,
   // Stream toward the device
   input wire logic i_ready,
   output logic o_valid,
   output rxc_pkg::rxc_desc_s o_desc
);
   import rxc_pkg::*;

   initial begin
      o_valid = 1'b0;
      o_desc = '0;
   end

   // Offer one frame, hold it until taken or the wait runs out
   task automatic send(input rxc_desc_s d, input int lim, output logic ok);
      int n;
      n = 0;
      ok = 1'b0;
      o_valid <= 1'b1;
      o_desc <= d;
      while (!ok && n < lim) begin
         @(posedge i_core_clk);
         ok = (i_ready === 1'b1);
         n++;
      end
      // Junk on release; one idle edge before the next offer
      o_valid <= 1'b0;
      o_desc <= ~d;
      @(posedge i_core_clk);
   endtask
endmodule // rxc_station

`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import rxc_pkg::*;

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   typedef struct packed {
      logic [15:0] ctl;
      rxc_desc_s d;
      logic keep;
   } rxc_row_s;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic dup = 1'b1;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'h3;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack, rx_valid, rx_ready, tx_hold, running, ok;
   rxc_desc_s rx_desc, pd;
   rxc_row_s rows [12];
   logic [31:0] q;
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int acc;

   rxc_rx_control uut (.i_core_clk(core_clk), .i_sys_rst(sys_rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
      .o_wb_dat(rdat), .o_wb_ack(ack), .i_rx_valid(rx_valid), .i_rx_desc(rx_desc),
      .o_rx_ready(rx_ready), .i_full_duplex(dup), .o_tx_hold(tx_hold),
      .o_rx_running(running));
   rxc_station stn (.i_core_clk(core_clk), .i_ready(rx_ready), .o_valid(rx_valid),
      .o_desc(rx_desc));

   // Clock and hang guard, ceiling well above the planned run
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         end_of_test();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Classic single cycle; the slave decides when ack comes
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = rdat;
      if (ack !== 1'b1) bad_count++;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0000_0000);
      chk(nm, e, q);
   endtask

   function automatic rxc_desc_s mk(input logic [10:0] len, input logic [6:0] f,
      input rxc_dst_e k, input logic m);
      mk = '0;
      mk.frame_len = len;
      {mk.crc_err, mk.is_ip, mk.ip_bad, mk.is_tcp, mk.tcp_bad, mk.is_udp, mk.udp_bad} = f;
      mk.dst_kind = k;
      mk.addr_match = m;
   endfunction

   // Expected queue word for a kept frame
   function automatic logic [31:0] ent(input rxc_desc_s d);
      ent = {15'h0, 1'b1, d.crc_err, d.is_ip, d.is_tcp, d.is_udp, 1'b0, d.frame_len};
   endfunction

   task automatic end_of_test;
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      // Control value, descriptor, kept or not
      rows[0] = '{16'h4801, mk(11'd64, 7'b0100011, RXC_DST_BCAST, 1'b0), 1'b0};
      rows[1] = '{16'h0801, mk(11'd65, 7'b0100011, RXC_DST_BCAST, 1'b0), 1'b1};
      rows[2] = '{16'h2801, mk(11'd66, 7'b0101100, RXC_DST_BCAST, 1'b0), 1'b0};
      rows[3] = '{16'h0801, mk(11'd67, 7'b0101100, RXC_DST_BCAST, 1'b0), 1'b1};
      rows[4] = '{16'h1801, mk(11'd68, 7'b0110000, RXC_DST_BCAST, 1'b0), 1'b0};
      rows[5] = '{16'h0A01, mk(11'd69, 7'b1000000, RXC_DST_BCAST, 1'b0), 1'b1};
      rows[6] = '{16'h0801, mk(11'd70, 7'b1000000, RXC_DST_BCAST, 1'b0), 1'b0};
      rows[7] = '{16'h0801, mk(11'd71, 7'b0000000, RXC_DST_UNI, 1'b1), 1'b1};
      rows[8] = '{16'h0001, mk(11'd72, 7'b0000000, RXC_DST_UNI, 1'b1), 1'b0};
      rows[9] = '{16'h0101, mk(11'd73, 7'b0000000, RXC_DST_MULTI, 1'b1), 1'b1};
      rows[10] = '{16'h0001, mk(11'd74, 7'b0000000, RXC_DST_MULTI, 1'b1), 1'b0};
      rows[11] = '{16'h0801, mk(11'd75, 7'b0000000, RXC_DST_UNI, 1'b0), 1'b0};
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      // Reset values and an unmapped place
      rdc("control", RXC_RXCTL_OFF, 32'h0000_0800);
      rdc("status", RXC_STATUS_OFF, 32'h0000_0000);
      chk("ready", 32'h0, {31'h0, rx_ready});
      wb(1'b1, 8'h10, 32'hFFFF_FFFF);
      rdc("unmapped", 8'h10, 32'h0000_0000);
      $display("reset test done");
      // Filter and check table
      foreach (rows[i]) begin
         wb(1'b1, RXC_RXCTL_OFF, {16'h0, rows[i].ctl});
         rdc("control", RXC_RXCTL_OFF, {16'h0, rows[i].ctl});
         stn.send(rows[i].d, 20, ok);
         chk("taken", 32'h1, {31'h0, ok});
         rdc("queue", RXC_RXQ_OFF, rows[i].keep ? ent(rows[i].d) : 32'h0);
         $display("row %0d done", i);
      end
      // Fill the queue until refused, then drain in order
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_0801);
      acc = 0;
      for (int k = 0; k < 40; k++) begin
         stn.send(mk(11'(k), 7'b0, RXC_DST_BCAST, 1'b0), 20, ok);
         if (!ok) break;
         acc++;
      end
      chk("accepted", 32'(RXC_FIFO_DEPTH), 32'(acc));
      for (int k = 0; k < RXC_FIFO_DEPTH; k++) begin
         rdc("drain", RXC_RXQ_OFF, ent(mk(11'(k), 7'b0, RXC_DST_BCAST, 1'b0)));
      end
      rdc("empty", RXC_RXQ_OFF, 32'h0000_0000);
      $display("fill test done");
      // Flush with two frames queued
      repeat (2) stn.send(mk(11'd99, 7'b0, RXC_DST_BCAST, 1'b0), 20, ok);
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_0800);
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_8800);
      wb(1'b0, RXC_STATUS_OFF, 32'h0);
      chk("count", 32'h0, {26'h0, q[5:0]});
      chk("pointer", 32'h0, {24'h0, q[15:8]});
      chk("ready", 32'h0, {31'h0, rx_ready});
      rdc("flushed", RXC_RXQ_OFF, 32'h0000_0000);
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_0801);
      stn.send(mk(11'd98, 7'b0, RXC_DST_BCAST, 1'b0), 20, ok);
      rdc("resumed", RXC_RXQ_OFF, ent(mk(11'd98, 7'b0, RXC_DST_BCAST, 1'b0)));
      $display("flush test done");
      // Pause honoured in full duplex
      pd = mk(11'd64, 7'b0, RXC_DST_BCAST, 1'b0);
      pd.is_pause = 1'b1;
      pd.pause_quanta = 16'h0001;
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_0C01);
      stn.send(pd, 20, ok);
      repeat (2) @(posedge core_clk);
      #1 chk("hold", 32'h1, {31'h0, tx_hold});
      repeat (520) @(posedge core_clk);
      #1 chk("hold", 32'h0, {31'h0, tx_hold});
      rdc("pause", RXC_RXQ_OFF, 32'h0000_0000);
      pd.pause_quanta = 16'h0004;
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_0801);
      stn.send(pd, 20, ok);
      repeat (3) @(posedge core_clk);
      #1 chk("hold", 32'h0, {31'h0, tx_hold});
      // Half duplex, enable kept low by software
      dup <= 1'b0;
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_0801);
      repeat (8) @(posedge core_clk);
      stn.send(pd, 20, ok);
      repeat (3) @(posedge core_clk);
      #1 chk("hold", 32'h0, {31'h0, tx_hold});
      $display("pause test done");
      // Stop reception
      wb(1'b1, RXC_RXCTL_OFF, 32'h0000_0800);
      repeat (3) @(posedge core_clk);
      #1 chk("running", 32'h0, {31'h0, running});
      stn.send(pd, 10, ok);
      chk("refused", 32'h0, {31'h0, ok});
      $display("stop test done");
      end_of_test();
   end
endmodule // testbench

`default_nettype wire
